/* core/pfc_regs.sv */
// Purpose: Control, status and threshold registers with video pass-through timing
// Assumes: One clock for video and the AXI4-Lite slave; inputs synchronous to it
// Notes: Detection and interpolation live outside; they read the working thresholds
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_regs #(
    parameter int DATA_WIDTH = 8,
    parameter int ADDR_WIDTH = 9,
    parameter int VIDEO_DELAY = `PFC_VIDEO_DELAY
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sclr,
    input wire logic [DATA_WIDTH-1:0] video_data_in,
    input wire logic hblank_in,
    input wire logic vblank_in,
    input wire logic active_video_in,
    output logic [DATA_WIDTH-1:0] video_data_out,
    output logic hblank_out,
    output logic vblank_out,
    output logic active_video_out,
    input wire logic fifo_empty,
    input wire logic fifo_full,
    input wire logic candidate_seen,
    input wire logic pixel_corrected,
    output logic [31:0] temporal_limit_work,
    output logic [31:0] spatial_limit_work,
    output logic [31:0] age_limit_work,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int BUNDLE = DATA_WIDTH + 3;
    localparam logic [31:0] TEMPORAL_RESET = 32'h00000001 << (DATA_WIDTH - 7);
    // Named copy so single status bits can be selected
    localparam logic [31:0] STATUS_RESET = `PFC_STATUS_RESET;
    localparam pfc_pkg::pfc_thr_t THR_RESET = '{
        temporal: TEMPORAL_RESET,
        spatial: `PFC_SPATIAL_RESET,
        age: `PFC_AGE_RESET
    };

    // only 8, 10 or 12 bits
    if (!(DATA_WIDTH == 8 || DATA_WIDTH == 10 || DATA_WIDTH == 12)) begin : g_bad_width
        $error("pfc_regs supports DATA_WIDTH of 8, 10 or 12 only");
    end
    if (ADDR_WIDTH < 5) begin : g_bad_addr
        $error("pfc_regs needs ADDR_WIDTH of at least 5");
    end

    pfc_pkg::pfc_state_t s;
    pfc_pkg::pfc_state_t next_s;

    logic wr_go;
    logic rd_go;
    logic vblank_rise;
    logic video_pass;
    logic pipe_clear;
    logic [BUNDLE-1:0] pipe_in;
    logic [BUNDLE-1:0] pipe_out;

    // Decoder shared by read and write: {hit, word index}
    function automatic logic [3:0] reg_sel(input logic [ADDR_WIDTH-1:0] addr);
        logic hit;
        // Shift keeps the compare legal at the minimum address width
        hit = ((addr >> 5) == '0) && (addr[1:0] == 2'h0);
        return {hit, addr[4:2]};
    endfunction

    // Byte-lane merge so partial writes keep untouched lanes
    function automatic logic [31:0] merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] read_word(
        input pfc_pkg::pfc_state_t st,
        input logic [2:0] idx
    );
        logic [31:0] w;
        w = '0;
        case (idx)
            3'h0: w[1:0] = st.control;
            3'h1: w[`PFC_RST_BIT] = st.soft_reset;
            3'h2: begin
                w[`PFC_ST_EMPTY] = st.fifo_empty;
                w[`PFC_ST_FULL] = st.fifo_full;
                w[`PFC_ST_LOCK] = (st.lock == pfc_pkg::PFC_LOCKED);
            end
            3'h3: w = st.shadow.temporal;
            3'h4: w = st.shadow.spatial;
            3'h5: w = st.shadow.age;
            3'h6: w = st.cand_last;
            3'h7: w = st.corr_last;
            default: w = '0;
        endcase
        return w;
    endfunction

    // One write in flight; response must drain before the next is taken
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
    assign rd_go = s_axi_arvalid && !s.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign vblank_rise = vblank_in && !s.vblank_prev;

    assign video_pass = s.control[`PFC_CTL_ENABLE] && !s.soft_reset;
    assign pipe_clear = sclr || s.soft_reset;
    assign pipe_in = video_pass ?
        {video_data_in, hblank_in, vblank_in, active_video_in} : '0;

    always_comb begin
        logic [3:0] wsel;
        logic [3:0] rsel;
        logic [31:0] cand_now;
        logic [31:0] corr_now;
        logic [31:0] ctl_word;
        logic [31:0] rst_word;
        wsel = reg_sel(s_axi_awaddr);
        rsel = reg_sel(s_axi_araddr);
        cand_now = s.cand_run + {31'h0, candidate_seen};
        corr_now = s.corr_run + {31'h0, pixel_corrected};
        ctl_word = merge({30'h0, s.control}, s_axi_wdata, s_axi_wstrb);
        rst_word = merge({31'h0, s.soft_reset}, s_axi_wdata, s_axi_wstrb);
        next_s = s;

        // Response channels clear on handshake
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        if (ce) begin
            next_s.vblank_prev = vblank_in;
            next_s.fifo_empty = fifo_empty;
            next_s.fifo_full = fifo_full;
            if (s.control[`PFC_CTL_ENABLE]) begin
                next_s.cand_run = cand_now;
                next_s.corr_run = corr_now;
            end
            if (vblank_rise) begin
                next_s.cand_last = s.control[`PFC_CTL_ENABLE] ? cand_now : s.cand_run;
                next_s.corr_last = s.control[`PFC_CTL_ENABLE] ? corr_now : s.corr_run;
                next_s.cand_run = '0;
                next_s.corr_run = '0;
                case (s.lock)
                    pfc_pkg::PFC_HUNT: next_s.lock = pfc_pkg::PFC_SEEN;
                    pfc_pkg::PFC_SEEN: next_s.lock = pfc_pkg::PFC_LOCKED;
                    pfc_pkg::PFC_LOCKED: next_s.lock = pfc_pkg::PFC_LOCKED;
                    default: next_s.lock = pfc_pkg::PFC_HUNT;
                endcase
                if (s.control[`PFC_CTL_SEMAPHORE]) begin
                    next_s.work = s.shadow;
                end
            end
        end

        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = wsel[3] ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            if (wsel[3]) begin
                case (wsel[2:0])
                    3'h0: next_s.control = ctl_word[1:0];
                    3'h1: next_s.soft_reset = rst_word[`PFC_RST_BIT];
                    3'h3: next_s.shadow.temporal =
                        merge(s.shadow.temporal, s_axi_wdata, s_axi_wstrb);
                    3'h4: next_s.shadow.spatial =
                        merge(s.shadow.spatial, s_axi_wdata, s_axi_wstrb);
                    3'h5: next_s.shadow.age =
                        merge(s.shadow.age, s_axi_wdata, s_axi_wstrb);
                    default: next_s.control = next_s.control;
                endcase
            end
        end

        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = rsel[3] ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            next_s.rdata = rsel[3] ? read_word(s, rsel[2:0]) : '0;
        end

        if (s.soft_reset) begin
            next_s.shadow = THR_RESET;
            next_s.work = THR_RESET;
            next_s.lock = pfc_pkg::PFC_HUNT;
            next_s.vblank_prev = 1'b0;
            next_s.cand_run = '0;
            next_s.corr_run = '0;
        end

        // clear overrides ce
        // Bus handshake state is kept so an open transfer still completes
        if (sclr) begin
            next_s.control = `PFC_CONTROL_RESET;
            next_s.soft_reset = 1'b0;
            next_s.shadow = THR_RESET;
            next_s.work = THR_RESET;
            next_s.vblank_prev = 1'b0;
            next_s.lock = pfc_pkg::PFC_HUNT;
            next_s.fifo_empty = STATUS_RESET[`PFC_ST_EMPTY];
            next_s.fifo_full = 1'b0;
            next_s.cand_run = `PFC_COUNT_RESET;
            next_s.corr_run = `PFC_COUNT_RESET;
            next_s.cand_last = `PFC_COUNT_RESET;
            next_s.corr_last = `PFC_COUNT_RESET;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s.control <= `PFC_CONTROL_RESET;
            s.soft_reset <= 1'b0;
            s.shadow <= THR_RESET;
            s.work <= THR_RESET;
            s.vblank_prev <= 1'b0;
            s.lock <= pfc_pkg::PFC_HUNT;
            s.fifo_empty <= STATUS_RESET[`PFC_ST_EMPTY];
            s.fifo_full <= 1'b0;
            s.cand_run <= `PFC_COUNT_RESET;
            s.corr_run <= `PFC_COUNT_RESET;
            s.cand_last <= `PFC_COUNT_RESET;
            s.corr_last <= `PFC_COUNT_RESET;
            s.bvalid <= 1'b0;
            s.bresp <= `PFC_RESP_OKAY;
            s.rvalid <= 1'b0;
            s.rresp <= `PFC_RESP_OKAY;
            s.rdata <= '0;
        end else begin
            s <= next_s;
        end
    end

    pfc_video_delay #(
        .WIDTH(BUNDLE),
        .DEPTH(VIDEO_DELAY)
    ) u_delay (
        .clock(clock),
        .nrst(nrst),
        .advance(ce),
        .clear(pipe_clear),
        .din(pipe_in),
        .dout(pipe_out)
    );

    assign video_data_out = pipe_out[BUNDLE-1:3];
    assign hblank_out = pipe_out[2];
    assign vblank_out = pipe_out[1];
    assign active_video_out = pipe_out[0];

    assign temporal_limit_work = s.work.temporal;
    assign spatial_limit_work = s.work.spatial;
    assign age_limit_work = s.work.age;

    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;

endmodule

/* core/pfc_video_delay.sv */
// Purpose: Fixed-length delay line for pixel data and its timing flags
// Assumes: advance is the clock enable, clear is synchronous
// Notes: Depth is fixed at build time so flags stay in phase with data
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_video_delay #(
    parameter int WIDTH = 11,
    parameter int DEPTH = `PFC_VIDEO_DELAY
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic advance,
    input wire logic clear,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] stage;
    } pfc_delay_state_t;

    pfc_delay_state_t s;
    pfc_delay_state_t next_s;

    if (DEPTH < 1) begin : g_bad_depth
        $error("pfc_video_delay needs DEPTH of at least one");
    end

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s.stage = '0;
        end else if (advance) begin
            next_s.stage[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                next_s.stage[i] = s.stage[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.stage[DEPTH-1];

endmodule

/* shared/pfc_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the register bank
// Assumes: 32-bit register words on byte addresses, one word per register
// Notes: Included by both design files and by the checker
// How it works
// - Status bit7 timing lock, bits2-6 zero
// - Temporal limit defaults to 2**(width-7)
// - Spatial limit defaults to 0x199a
// - Outlier age limit defaults to 0x4b0
// - Candidate count of previous frame, reset zero
// - Corrected count of previous frame, reset zero
// - Control, soft reset and thresholds read back; status and counts ignore writes
// - Enable bit low blocks video; resets one
// - Soft reset clears timing, restores thresholds
// - Soft reset forces video outputs to zero
// - Thresholds have shadow and working copies
// - Host writes reach the shadow only
// - Reads of thresholds return shadow copy
// - Vblank rise copies shadow when semaphore set
// - Clock enable low freezes video logic
// - Synchronous clear beats enable, forces defaults
// - Timing outputs delayed with the data
// - Pixel width only 8, 10 or 12
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define PFC_OFF_CONTROL 9'h000
`define PFC_OFF_SOFT_RESET 9'h004
`define PFC_OFF_STATUS 9'h008
`define PFC_OFF_TEMPORAL 9'h00c
`define PFC_OFF_SPATIAL 9'h010
`define PFC_OFF_AGE 9'h014
`define PFC_OFF_CANDIDATES 9'h018
`define PFC_OFF_CORRECTED 9'h01c

`define PFC_CTL_ENABLE 0
`define PFC_CTL_SEMAPHORE 1
`define PFC_RST_BIT 0
`define PFC_ST_EMPTY 0
`define PFC_ST_FULL 1
`define PFC_ST_LOCK 7

`define PFC_CONTROL_RESET 2'h1
`define PFC_STATUS_RESET 32'h00000001
`define PFC_SPATIAL_RESET 32'h0000199a
`define PFC_AGE_RESET 32'h000004b0
`define PFC_COUNT_RESET 32'h00000000

`define PFC_VIDEO_DELAY 2
`define PFC_RESP_OKAY 2'h0
`define PFC_RESP_SLVERR 2'h2

`endif

/* shared/pfc_pkg.sv */
// Purpose: Types of the register bank state; the video delay line keeps its own
// Assumes: Constants live in pfc_defs.svh
// Notes: Nothing here is imported; users write pfc_pkg::name
package pfc_pkg;

    typedef enum logic [1:0] {
        PFC_HUNT = 2'b00,
        PFC_SEEN = 2'b01,
        PFC_LOCKED = 2'b10
    } pfc_lock_t;

    typedef struct packed {
        logic [31:0] temporal;
        logic [31:0] spatial;
        logic [31:0] age;
    } pfc_thr_t;

    typedef struct packed {
        logic [1:0] control;
        logic soft_reset;
        pfc_thr_t shadow;
        pfc_thr_t work;
        logic vblank_prev;
        pfc_lock_t lock;
        logic fifo_empty;
        logic fifo_full;
        logic [31:0] cand_run;
        logic [31:0] corr_run;
        logic [31:0] cand_last;
        logic [31:0] corr_last;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pfc_state_t;

endpackage

/* test/pfc_regs_sva.sv */
// Purpose: Port-level checks of the register bank and video path
// Assumes: One clock domain, nrst async active low
// Notes: Enable and soft reset are internal, so video checks lean on ce and sclr
`timescale 1ns/1ps
`include "pfc_defs.svh"
module pfc_regs_sva #(
    parameter int DATA_WIDTH = 8,
    parameter int ADDR_WIDTH = 9,
    parameter int VIDEO_DELAY = 2
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sclr,
    input wire logic vblank_in,
    input wire logic [DATA_WIDTH-1:0] video_data_out,
    input wire logic vblank_out,
    input wire logic active_video_out,
    input wire logic [31:0] spatial_limit_work,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence wr_take;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write taken without response");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read taken without data");
    bresp_stand_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_stand_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    bad_addr_a: assert property (rd_take and s_axi_araddr[1:0] != 2'h0
        |=> s_axi_rresp == `PFC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad address");
    sclr_zero_a: assert property (sclr |=> video_data_out == '0 && !vblank_out
        && !active_video_out && spatial_limit_work == `PFC_SPATIAL_RESET)
        else $error("clear left outputs set");
    ce_hold_a: assert property (!ce && !sclr |=> $stable(video_data_out)
        && $stable(vblank_out) && $stable(active_video_out)) else $error("moved with ce low");
    work_gate_a: assert property (!$stable(spatial_limit_work) |-> $past(sclr)
        || $past(ce && vblank_in) || spatial_limit_work == `PFC_SPATIAL_RESET)
        else $error("working copy changed mid frame");
endmodule
bind pfc_regs pfc_regs_sva #(
    .DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH), .VIDEO_DELAY(VIDEO_DELAY)
) u_sva (
    .clock(clock), .nrst(nrst), .ce(ce), .sclr(sclr), .vblank_in(vblank_in),
    .video_data_out(video_data_out), .vblank_out(vblank_out),
    .active_video_out(active_video_out), .spatial_limit_work(spatial_limit_work),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* test/pfc_video_src.sv */
// Purpose: Upstream video source and detector pulses for the register bank bench
// Assumes: 64-cycle frames, 40 active pixels, vblank in the last 16 cycles
// Notes: Freezes with ce low; data outside active is junk that moves with the count
`timescale 1ns/1ps
module pfc_video_src #(
    parameter int DATA_WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic run,
    output logic [DATA_WIDTH-1:0] data,
    output logic hblank,
    output logic vblank,
    output logic active,
    output logic cand,
    output logic corr
);
    logic [5:0] cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt <= 6'h00;
        end else if (ce && run) begin
            cnt <= cnt + 6'h01;
        end
    end
    // active only with a valid pixel
    assign active = run && cnt < 6'h28;
    // unsigned samples; inverse junk when idle
    assign data = DATA_WIDTH'(active ? cnt : ~cnt);
    assign hblank = !run || cnt >= 6'h28;
    assign vblank = cnt >= 6'h30;
    assign cand = run && cnt == 6'h05;
    assign corr = run && (cnt == 6'h05 || cnt == 6'h06);
endmodule

/* test/tb_top.sv */
// Purpose: Self-checking bench for the register bank and its video delay
// Assumes: DATA_WIDTH 8, so the temporal default is 2
// Notes: Response ready held back one cycle to exercise the standing response
`timescale 1ns/1ps
`include "pfc_defs.svh"
module tb_top;
    logic clock = 0, nrst = 0, ce = 1, sclr = 0, run = 0, fe = 1, ff = 0, cs, pc;
    logic [7:0] vd, dout;
    logic hb, vb, av, ho, vo, ao, awv = 0, wv = 0, awr, wr_rdy, bv, bready = 0;
    logic arv = 0, arr, rv, rready = 0;
    logic [31:0] tw, sw, agw, wdata = 0, rdata, rval;
    logic [8:0] awaddr = 0, araddr = 0;
    logic [3:0] wstrb = 4'hf, strb = 4'hf;
    logic [1:0] br, rresp, rres;
    logic [10:0] snap;
    int bad_count = 0, tests_run = 0;
    pfc_video_src #(.DATA_WIDTH(8)) src (.clock(clock), .nrst(nrst), .ce(ce), .run(run),
        .data(vd), .hblank(hb), .vblank(vb), .active(av), .cand(cs), .corr(pc));
    pfc_regs #(.DATA_WIDTH(8)) dut (.clock(clock), .nrst(nrst), .ce(ce), .sclr(sclr),
        .video_data_in(vd), .hblank_in(hb), .vblank_in(vb), .active_video_in(av),
        .video_data_out(dout), .hblank_out(ho), .vblank_out(vo), .active_video_out(ao),
        .fifo_empty(fe), .fifo_full(ff), .candidate_seen(cs), .pixel_corrected(pc),
        .temporal_limit_work(tw), .spatial_limit_work(sw), .age_limit_work(agw),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
    initial begin
        forever #20 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awv <= 1;
        wv <= 1;
        @(negedge clock);
        for (n = 0; n < 9 && !awr; n++) @(negedge clock);
        chk({awr, wr_rdy}, 32'h3);
        @(posedge clock);
        awv <= 0;
        wv <= 0;
        @(negedge clock);
        chk({bv, br}, 32'h4);
        @(posedge clock);
        bready <= 1;
        @(posedge clock);
        bready <= 0;
    endtask
    task automatic rc(input logic [8:0] a, input logic [31:0] exp);
        int n;
        @(posedge clock);
        araddr <= a;
        arv <= 1;
        @(negedge clock);
        for (n = 0; n < 9 && !arr; n++) @(negedge clock);
        chk(arr, 32'h1);
        @(posedge clock);
        arv <= 0;
        @(negedge clock);
        rval = rdata;
        rres = rresp;
        chk(rval, exp);
        @(posedge clock);
        rready <= 1;
        @(posedge clock);
        rready <= 0;
    endtask
    task automatic t_defaults;
        rc(9'h000, 32'h1);
        rc(9'h004, 32'h0);
        rc(9'h008, `PFC_STATUS_RESET);
        rc(9'h00c, 32'h2);
        rc(9'h010, `PFC_SPATIAL_RESET);
        rc(9'h014, `PFC_AGE_RESET);
        chk(tw, 32'h2);
        wr(9'h018, 32'hffffffff);
        wr(9'h008, 32'hffffffff);
        rc(9'h018, 32'h0);
        rc(9'h01c, 32'h0);
        rc(9'h008, 32'h1);
        rc(9'h022, 32'h0);
        chk(rres, `PFC_RESP_SLVERR);
    endtask
    task automatic t_shadow;
        wr(9'h000, 32'h1);
        fe <= 0;
        ff <= 1;
        run <= 1;
        wr(9'h010, 32'h1234);
        rc(9'h010, 32'h1234);
        repeat (140) @(posedge clock);
        @(negedge clock);
        chk(sw, `PFC_SPATIAL_RESET);
        rc(9'h008, 32'h82);
        rc(9'h018, 32'h1);
        rc(9'h01c, 32'h2);
        wr(9'h000, 32'h3);
        repeat (70) @(posedge clock);
        @(negedge clock);
        chk(sw, 32'h1234);
    endtask
    task automatic t_delay;
        repeat (6) begin
            @(negedge clock);
            snap = {vd, hb, vb, av};
            repeat (2) @(posedge clock);
            @(negedge clock);
            chk({dout, ho, vo, ao}, snap);
        end
    endtask
    task automatic t_enable_ce;
        @(posedge clock);
        ce <= 0;
        @(negedge clock);
        snap = {dout, ho, vo, ao};
        repeat (5) @(negedge clock);
        chk({dout, ho, vo, ao}, snap);
        @(posedge clock);
        ce <= 1;
        wr(9'h000, 32'h2);
        repeat (3) @(posedge clock);
        @(negedge clock);
        chk({dout, ho, vo, ao}, 32'h0);
        wr(9'h000, 32'h3);
    endtask
    task automatic t_soft_sclr;
        wr(9'h000, 32'h1);
        strb = 4'h1;
        wr(9'h014, 32'hffffffff);
        strb = 4'hf;
        rc(9'h014, 32'h4ff);
        wr(9'h004, 32'h1);
        @(negedge clock);
        chk({dout, ho, vo, ao}, 32'h0);
        chk(agw, `PFC_AGE_RESET);
        rc(9'h014, `PFC_AGE_RESET);
        wr(9'h004, 32'h0);
        wr(9'h000, 32'h0);
        wr(9'h010, 32'h5);
        @(posedge clock);
        sclr <= 1;
        @(posedge clock);
        sclr <= 0;
        rc(9'h000, 32'h1);
        rc(9'h010, `PFC_SPATIAL_RESET);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1;
        t_defaults();
        t_shadow();
        t_delay();
        t_enable_ce();
        t_soft_sclr();
        give_verdict();
    end
    // Whole sequence needs under 1000 cycles
    initial begin
        repeat (5000) @(posedge clock);
        bad_count++;
        give_verdict();
    end
endmodule
